// ==== verilog/cit_pkg.sv ====
package cit_pkg;
  // register byte offsets
  localparam logic [7:0] CIT_OFS_MODE = 8'h00;
  localparam logic [7:0] CIT_OFS_COUNT = 8'h04;
  localparam logic [7:0] CIT_OFS_FALL_CAP = 8'h08;
  localparam logic [7:0] CIT_OFS_RISE_CAP = 8'h0C;
  localparam logic [7:0] CIT_OFS_PORT_FN = 8'h10;
  localparam logic [7:0] CIT_OFS_REQ_FLAG = 8'h14;
  localparam logic [7:0] CIT_OFS_IRQ_EN = 8'h18;
  localparam logic [7:0] CIT_OFS_CLK_HALT = 8'h1C;
  // timer_mode_register fields
  localparam int unsigned CIT_MODE_OVERFLOW_HIGH_FLAG_BIT = 7;
  localparam int unsigned CIT_MODE_OVERFLOW_LOW_FLAG_BIT = 6;
  localparam int unsigned CIT_MODE_OVERFLOW_IRQ_ENABLE_BIT = 5;
  localparam int unsigned CIT_MODE_INTERRUPT_EDGE_SELECT_BIT = 4;
  localparam int unsigned CIT_MODE_CCLR_LSB = 2;
  localparam int unsigned CIT_MODE_CKS_LSB = 0;
  // port_function_register fields
  localparam int unsigned CIT_PFN_CAPFN_BIT = 0;
  localparam int unsigned CIT_PFN_FILTEN_BIT = 1;
  // single-bit registers sit in bit 0
  localparam int unsigned CIT_FLAG_BIT = 0;
  localparam logic [7:0] CIT_MODE_RESET = 8'h00;
  localparam logic [7:0] CIT_COUNT_MAX = 8'hFF;
  localparam logic [7:0] CIT_COUNT_ZERO = 8'h00;
  // count source select codes
  localparam logic [1:0] CIT_CKS_DIV64 = 2'h0;
  localparam logic [1:0] CIT_CKS_DIV32 = 2'h1;
  localparam logic [1:0] CIT_CKS_DIV2 = 2'h2;
  localparam logic [1:0] CIT_CKS_WDIV4 = 2'h3;
  // counter clear codes
  localparam logic [1:0] CIT_CCLR_NONE = 2'h0;
  localparam logic [1:0] CIT_CCLR_FALL = 2'h1;
  localparam logic [1:0] CIT_CCLR_RISE = 2'h2;
  localparam logic [1:0] CIT_CCLR_BOTH = 2'h3;
  // prescaler taps: bit n of a free counter toggles at clk/2^(n+1)
  localparam int unsigned CIT_DIV_W = 6;
  localparam int unsigned CIT_TAP_DIV64 = 5;
  localparam int unsigned CIT_TAP_DIV32 = 4;
  localparam int unsigned CIT_TAP_DIV2 = 0;
  localparam int unsigned CIT_TAP_WDIV4 = 1;
  localparam int unsigned CIT_FILT_STAGES = 5;
  localparam logic [1:0] CIT_HTRANS_IDLE = 2'h0;
  typedef enum logic [2:0] {
    CIT_PM_ACTIVE, CIT_PM_SLEEP, CIT_PM_WATCH, CIT_PM_SUBACTIVE, CIT_PM_SUBSLEEP,
    CIT_PM_STANDBY
  } cit_power_mode_t;
  typedef enum logic [1:0] {CIT_SUB_W8, CIT_SUB_W4, CIT_SUB_W2} cit_subclk_t;
endpackage

// ==== verilog/cit_prescaler.sv ====
`timescale 1ns/100ps
module cit_prescaler (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic watch_clk_in,
  input wire logic [1:0] cks_in,
  output logic fall_tick_out,
  output logic rise_tick_out
);
  import cit_pkg::*;

  typedef struct packed {
    logic [CIT_DIV_W-1:0] div;
    logic w_s1;
    logic w_s2;
    logic w_prev;
    logic [1:0] wdiv;
    logic sel_prev;
  } cit_psc_state_t;

  cit_psc_state_t st_ff;
  cit_psc_state_t nxt_st;
  logic sel_lvl;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.div = st_ff.div + CIT_DIV_W'(1);
    // watch clock is asynchronous: two flops, up to one system period of jitter
    nxt_st.w_s1 = watch_clk_in;
    nxt_st.w_s2 = st_ff.w_s1;
    nxt_st.w_prev = st_ff.w_s2;
    if (st_ff.w_s2 && !st_ff.w_prev) begin
      nxt_st.wdiv = st_ff.wdiv + 2'h1;
    end
    case (cks_in)
      CIT_CKS_DIV64: sel_lvl = st_ff.div[CIT_TAP_DIV64];
      CIT_CKS_DIV32: sel_lvl = st_ff.div[CIT_TAP_DIV32];
      CIT_CKS_DIV2: sel_lvl = st_ff.div[CIT_TAP_DIV2];
      CIT_CKS_WDIV4: sel_lvl = st_ff.wdiv[CIT_TAP_WDIV4];
      default: sel_lvl = 1'b0;
    endcase
    nxt_st.sel_prev = sel_lvl;
    // edges of the muxed level: a high-to-low source switch counts once
    fall_tick_out = st_ff.sel_prev && !sel_lvl;
    rise_tick_out = !st_ff.sel_prev && sel_lvl;
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

// ==== verilog/cit_noise_filter.sv ====
`timescale 1ns/100ps
module cit_noise_filter #(
  parameter int unsigned STAGES = cit_pkg::CIT_FILT_STAGES
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic din_in,
  input wire logic sample_in,
  output logic dout_out
);
  import cit_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0] sh;
    logic seen_high;
    logic init;
    logic out;
  } cit_filt_state_t;

  cit_filt_state_t st_ff;
  cit_filt_state_t nxt_st;
  logic all_hi;
  logic all_lo;

  always_comb begin
    nxt_st = st_ff;
    all_hi = &st_ff.sh;
    all_lo = ~|st_ff.sh;
    if (sample_in) begin
      nxt_st.sh = {st_ff.sh[STAGES-2:0], din_in};
      if (din_in) begin
        nxt_st.seen_high = 1'b1;
      end
      // first valid output only after a falling edge then all-low samples
      if (!st_ff.init && st_ff.seen_high && all_lo) begin
        nxt_st.init = 1'b1;
      end
      if (st_ff.init && all_hi) begin
        nxt_st.out = 1'b1;
      end else if (st_ff.init && all_lo) begin
        nxt_st.out = 1'b0;
      end
    end
    dout_out = st_ff.out;
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  chk_filt_holds_mixed: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (sample_in && !all_hi && !all_lo) |=> $stable(dout_out))
    else $error("filter output moved without agreement");
  chk_filt_init_low: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !st_ff.init |-> !dout_out)
    else $error("filter output high before init");
endmodule

// ==== verilog/cit_timer.sv ====
// Decided for this implementation: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
// Behaviour
// - filter shifts input through five latches; output changes only when all agree
// - sampling clock is system clock unfiltered, selected count clock when filtering
// - after reset filter output valid only after five low samples after a fall
// - filtered edges reach capture logic five sampling clocks late
// - function bit set gives capture timer, cleared gives interval timer
// - reset clears mode, counter, both captures; counting starts on clock/64
// - counter steps on clock/64, clock/32, clock/2 or watch clock/4
// - counter is eight-bit up-counter wrapping to zero in both functions
// - rising edge copies count to rising capture, falling to falling capture
// - edge chosen by edge select sets request flag; enable raises interrupt
// - capture mode clears counter on rising, falling or both edges
// - wrap while input high sets high overflow, while low sets low overflow
// - interval mode sets low overflow on every wrap from all-ones
// - overflow with overflow enable sets request flag; enable raises interrupt
// - toggling function or filter enable can produce a spurious edge
// - watch clock source synchronised to system clock, one-period error
// - watch mode runs only on watch clock/4; else no counting or capture
// - sub modes run only on watch clock/4 with subclock watch clock/2
// - source select codes 00 /64, 01 /32, 10 /2, 11 watch/4
// - clear codes 00 none, 01 falling, 10 rising, 11 both
// - overflow flags set by hardware, cleared by writing 0 after reading 1
module cit_timer (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic capture_pin_in,
  input wire logic watch_clk_in,
  input wire cit_pkg::cit_power_mode_t power_mode_in,
  input wire cit_pkg::cit_subclk_t subclk_sel_in,
  output logic timer_irq_out
);
  import cit_pkg::*;

  typedef struct packed {
    logic pin_s1;
    logic pin_s2;
    logic sig_prev;
    logic [7:0] cnt;
    logic [7:0] cap_rise;
    logic [7:0] cap_fall;
    logic overflow_high_flag;
    logic overflow_low_flag;
    logic overflow_irq_enable;
    logic interrupt_edge_select;
    logic [1:0] cclr;
    logic [1:0] cks;
    logic cap_fn;
    logic filt_en;
    logic req;
    logic ien;
    logic clk_stop;
    logic arm_overflow_high_flag;
    logic arm_overflow_low_flag;
    logic arm_req;
    logic dp_act;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
  } cit_state_t;

  cit_state_t st_ff;
  cit_state_t nxt_st;
  logic fall_tick;
  logic rise_tick;
  logic filt_out;
  logic filt_sample;
  logic pin_gated;
  logic sig;
  logic rise_evt;
  logic fall_evt;
  logic run_ok;
  logic cnt_en;
  logic edge_ok;
  logic clr_evt;
  logic wrap;
  logic set_overflow_high_flag;
  logic set_overflow_low_flag;
  logic req_set;
  logic addr_take;
  logic [7:0] a_ofs;
  logic [7:0] mode_val;
  logic [31:0] rd_val;

  cit_prescaler u_psc (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .watch_clk_in(watch_clk_in),
    .cks_in(st_ff.cks),
    .fall_tick_out(fall_tick),
    .rise_tick_out(rise_tick)
  );

  cit_noise_filter #(.STAGES(CIT_FILT_STAGES)) u_filt (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .din_in(pin_gated),
    .sample_in(filt_sample),
    .dout_out(filt_out)
  );

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pin_s1 = capture_pin_in;
    nxt_st.pin_s2 = st_ff.pin_s1;
    // low-power gating; standby and module stop halt counting, capture, filter sampling and edge/overflow requests
    case (power_mode_in)
      CIT_PM_ACTIVE, CIT_PM_SLEEP: run_ok = 1'b1;
      CIT_PM_WATCH: run_ok = (st_ff.cks == CIT_CKS_WDIV4);
      CIT_PM_SUBACTIVE, CIT_PM_SUBSLEEP:
        run_ok = (st_ff.cks == CIT_CKS_WDIV4) && (subclk_sel_in == CIT_SUB_W2);
      default: run_ok = 1'b0;
    endcase
    run_ok = run_ok && !st_ff.clk_stop;
    // pin reads low when not assigned; switching the bit can make an edge
    pin_gated = st_ff.cap_fn && st_ff.pin_s2;
    // filter runs on every clock when off; switching the enable can still make an edge on sig
    filt_sample = st_ff.filt_en ? (rise_tick && run_ok) : run_ok;
    sig = st_ff.filt_en ? filt_out : pin_gated;
    nxt_st.sig_prev = sig;
    rise_evt = sig && !st_ff.sig_prev;
    fall_evt = !sig && st_ff.sig_prev;
    cnt_en = fall_tick && run_ok;
    edge_ok = st_ff.cap_fn && run_ok;
    clr_evt = edge_ok && ((st_ff.cclr[0] && fall_evt) || (st_ff.cclr[1] && rise_evt));
    wrap = cnt_en && (st_ff.cnt == CIT_COUNT_MAX);
    set_overflow_high_flag = wrap && st_ff.cap_fn && sig;
    set_overflow_low_flag = wrap && (!st_ff.cap_fn || !sig);
    req_set = (edge_ok && (st_ff.interrupt_edge_select ? fall_evt : rise_evt)) ||
      (st_ff.overflow_irq_enable && (set_overflow_high_flag || set_overflow_low_flag));
    // clear beats increment in the same cycle
    if (clr_evt) begin
      nxt_st.cnt = CIT_COUNT_ZERO;
    end else if (cnt_en) begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
    end
    if (edge_ok && rise_evt) begin
      nxt_st.cap_rise = st_ff.cnt;
    end
    if (edge_ok && fall_evt) begin
      nxt_st.cap_fall = st_ff.cnt;
    end

    mode_val = {st_ff.overflow_high_flag, st_ff.overflow_low_flag, st_ff.overflow_irq_enable, st_ff.interrupt_edge_select, st_ff.cclr, st_ff.cks};
    addr_take = hsel_in && hready_in && htrans_in[1];
    a_ofs = haddr_in[7:0];
    case (a_ofs)
      CIT_OFS_MODE: rd_val = {24'h000000, mode_val};
      CIT_OFS_COUNT: rd_val = {24'h000000, st_ff.cnt};
      CIT_OFS_FALL_CAP: rd_val = {24'h000000, st_ff.cap_fall};
      CIT_OFS_RISE_CAP: rd_val = {24'h000000, st_ff.cap_rise};
      CIT_OFS_PORT_FN: rd_val = {30'h00000000, st_ff.filt_en, st_ff.cap_fn};
      CIT_OFS_REQ_FLAG: rd_val = {31'h00000000, st_ff.req};
      CIT_OFS_IRQ_EN: rd_val = {31'h00000000, st_ff.ien};
      CIT_OFS_CLK_HALT: rd_val = {31'h00000000, st_ff.clk_stop};
      default: rd_val = 32'h00000000;
    endcase
    nxt_st.dp_act = addr_take;
    nxt_st.dp_wr = hwrite_in;
    nxt_st.dp_addr = a_ofs;
    if (addr_take && !hwrite_in) begin
      nxt_st.rdata = rd_val;
      // a read that returns 1 arms the write-0 clear
      if (a_ofs == CIT_OFS_MODE) begin
        nxt_st.arm_overflow_high_flag = st_ff.overflow_high_flag;
        nxt_st.arm_overflow_low_flag = st_ff.overflow_low_flag;
      end
      if (a_ofs == CIT_OFS_REQ_FLAG) begin
        nxt_st.arm_req = st_ff.req;
      end
    end

    if (st_ff.dp_act && st_ff.dp_wr) begin
      case (st_ff.dp_addr)
        CIT_OFS_MODE: begin
          nxt_st.overflow_irq_enable = hwdata_in[CIT_MODE_OVERFLOW_IRQ_ENABLE_BIT];
          nxt_st.interrupt_edge_select = hwdata_in[CIT_MODE_INTERRUPT_EDGE_SELECT_BIT];
          nxt_st.cclr = hwdata_in[CIT_MODE_CCLR_LSB +: 2];
          nxt_st.cks = hwdata_in[CIT_MODE_CKS_LSB +: 2];
          // writing 1 never sets a flag
          if (st_ff.arm_overflow_high_flag && !hwdata_in[CIT_MODE_OVERFLOW_HIGH_FLAG_BIT]) begin
            nxt_st.overflow_high_flag = 1'b0;
          end
          if (st_ff.arm_overflow_low_flag && !hwdata_in[CIT_MODE_OVERFLOW_LOW_FLAG_BIT]) begin
            nxt_st.overflow_low_flag = 1'b0;
          end
          nxt_st.arm_overflow_high_flag = 1'b0;
          nxt_st.arm_overflow_low_flag = 1'b0;
        end
        CIT_OFS_PORT_FN: begin
          nxt_st.cap_fn = hwdata_in[CIT_PFN_CAPFN_BIT];
          nxt_st.filt_en = hwdata_in[CIT_PFN_FILTEN_BIT];
        end
        CIT_OFS_REQ_FLAG: begin
          if (st_ff.arm_req && !hwdata_in[CIT_FLAG_BIT]) begin
            nxt_st.req = 1'b0;
          end
          nxt_st.arm_req = 1'b0;
        end
        CIT_OFS_IRQ_EN: nxt_st.ien = hwdata_in[CIT_FLAG_BIT];
        CIT_OFS_CLK_HALT: nxt_st.clk_stop = hwdata_in[CIT_FLAG_BIT];
        default: nxt_st.ien = st_ff.ien;
      endcase
    end
    // hardware set wins over a same-cycle clear
    if (set_overflow_high_flag) begin
      nxt_st.overflow_high_flag = 1'b1;
    end
    if (set_overflow_low_flag) begin
      nxt_st.overflow_low_flag = 1'b1;
    end
    if (req_set) begin
      nxt_st.req = 1'b1;
    end
  end

  // reset zeroes mode (source /64), counter and captures
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // zero-wait slave; a read right after a write sees the old value
  assign hrdata_out = st_ff.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign timer_irq_out = st_ff.req && st_ff.ien;

  chk_reset_clears_all: assert property (@(posedge mclk_in)
    !nrst_in |=> (st_ff.cnt == CIT_COUNT_ZERO) && (mode_val == CIT_MODE_RESET) &&
      (st_ff.cap_rise == CIT_COUNT_ZERO) && (st_ff.cap_fall == CIT_COUNT_ZERO))
    else $error("reset did not clear timer state");
  chk_count_wraps: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (wrap && !clr_evt) |=> (st_ff.cnt == CIT_COUNT_ZERO))
    else $error("counter did not wrap to zero");
  chk_count_steps: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (cnt_en && !clr_evt) |=> (st_ff.cnt == 8'($past(st_ff.cnt) + 8'h01)))
    else $error("counter did not step by one");
  chk_rise_capture: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (edge_ok && rise_evt) |=> (st_ff.cap_rise == $past(st_ff.cnt)))
    else $error("rising capture missed count");
  chk_fall_capture: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (edge_ok && fall_evt) |=> (st_ff.cap_fall == $past(st_ff.cnt)))
    else $error("falling capture missed count");
  chk_clear_edges: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (edge_ok && (st_ff.cclr == CIT_CCLR_BOTH) && (rise_evt || fall_evt))
      |=> (st_ff.cnt == CIT_COUNT_ZERO))
    else $error("counter not cleared on edge");
  chk_ovf_high: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (wrap && st_ff.cap_fn && sig) |=> st_ff.overflow_high_flag)
    else $error("high overflow flag not set");
  chk_ovf_interval: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (wrap && !st_ff.cap_fn) |=> (st_ff.overflow_low_flag && !$rose(st_ff.overflow_high_flag)))
    else $error("interval overflow flag wrong");
  chk_req_on_edge: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (edge_ok && (st_ff.interrupt_edge_select ? fall_evt : rise_evt) && st_ff.ien) |=> timer_irq_out)
    else $error("edge did not raise request");
  chk_req_on_ovf: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ($rose(st_ff.overflow_low_flag) && $past(st_ff.overflow_irq_enable)) |-> st_ff.req)
    else $error("overflow did not raise request");
  chk_watch_gating: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ((power_mode_in == CIT_PM_WATCH) && (st_ff.cks != CIT_CKS_WDIV4))
      |=> $stable(st_ff.cnt) && $stable(st_ff.cap_rise))
    else $error("counter ran in watch mode");
  chk_flag_no_sw_set: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (!st_ff.overflow_high_flag && !set_overflow_high_flag) |=> !st_ff.overflow_high_flag)
    else $error("overflow flag set without wrap");

  chk_fall_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (edge_ok && (st_ff.cclr == CIT_CCLR_FALL) && fall_evt)
      |=> (st_ff.cnt == CIT_COUNT_ZERO))
    else $error("counter not cleared on falling edge");

  chk_rise_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (edge_ok && (st_ff.cclr == CIT_CCLR_RISE) && rise_evt)
      |=> (st_ff.cnt == CIT_COUNT_ZERO))
    else $error("counter not cleared on rising edge");

  chk_clear_off: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    ((st_ff.cclr == CIT_CCLR_NONE) && !cnt_en)
      |=> $stable(st_ff.cnt))
    else $error("counter moved with clearing off");

  chk_count_holds: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (!cnt_en && !clr_evt)
      |=> $stable(st_ff.cnt))
    else $error("counter moved without a tick");

  chk_sub_gating: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (((power_mode_in == CIT_PM_SUBACTIVE) || (power_mode_in == CIT_PM_SUBSLEEP)) &&
      (subclk_sel_in != CIT_SUB_W2)) |=> $stable(st_ff.cnt) && $stable(st_ff.cap_fall))
    else $error("counter ran in sub mode");

  chk_interval_nocap: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    !st_ff.cap_fn
      |=> $stable(st_ff.cap_rise) && $stable(st_ff.cap_fall))
    else $error("capture taken in interval mode");

  chk_ovf_low: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (wrap && st_ff.cap_fn && !sig)
      |=> st_ff.overflow_low_flag)
    else $error("low overflow flag not set");

  chk_req_fall_edge: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (edge_ok && st_ff.interrupt_edge_select && fall_evt)
      |=> st_ff.req)
    else $error("falling edge did not set request");

  chk_rise_single: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    rise_evt
      |=> !rise_evt)
    else $error("rising pulse longer than a cycle");

  chk_fall_single: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    fall_evt
      |=> !fall_evt)
    else $error("falling pulse longer than a cycle");

  chk_reset_source: assert property (@(posedge mclk_in)
    !nrst_in
      |=> (st_ff.cks == CIT_CKS_DIV64))
    else $error("reset did not select clock/64");

  chk_overflow_low_flag_no_sw: assert property (@(posedge mclk_in) disable iff (!nrst_in)
    (!st_ff.overflow_low_flag && !set_overflow_low_flag)
      |=> !st_ff.overflow_low_flag)
    else $error("low overflow flag set without wrap");
endmodule

// ==== dv/cit_pulse_src.sv ====
`timescale 1ns/100ps
module cit_pulse_src (
  input wire logic mclk_in,
  input wire logic start_in,
  input wire logic [15:0] hi_in,
  input wire logic [15:0] lo_in,
  input wire logic [1:0] count_in,
  output logic pin_out,
  output logic busy_out
);
  // pin is a plain driven input, no release: it rests low between pulses
  initial begin
    pin_out = 1'b0;
    busy_out = 1'b0;
    forever begin
      @(posedge mclk_in);
      if (start_in) begin
        busy_out <= 1'b1;
        for (int n = 0; n < count_in; n++) begin
          pin_out <= 1'b1;
          // widths come from the caller: >= 2 clocks unfiltered, >= 5 samples filtered
          repeat (hi_in) @(posedge mclk_in);
          pin_out <= 1'b0;
          repeat (lo_in) @(posedge mclk_in);
        end
        busy_out <= 1'b0;
      end
    end
  end
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import cit_pkg::*;
  logic mclk_in, nrst_in, hsel, hwrite, hreadyout, hresp, pin, watch_clk, irq, start, busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, n_p;
  logic [2:0] hsize;
  logic [15:0] hi_w, lo_w;
  logic [7:0] r;
  cit_power_mode_t pmode;
  cit_subclk_t subclk;
  logic [31:0] exp_q[$];
  string nm_q[$];
  int bad_count, tests_run;
  event rd_ev;
  // clears on both edges: 129 clocks high, 65 clocks low give exact counts
  logic [7:0] tabf[4] = '{8'h02, 8'h04, 8'h40, 8'h02};
  logic [7:0] tabr[4] = '{8'h01, 8'h02, 8'h20, 8'h01};
  cit_power_mode_t halt_m[4] = '{CIT_PM_WATCH, CIT_PM_SUBACTIVE, CIT_PM_SUBSLEEP, CIT_PM_STANDBY};

  cit_timer uut (
    .mclk_in(mclk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
    .hresp_out(hresp), .capture_pin_in(pin), .watch_clk_in(watch_clk),
    .power_mode_in(pmode), .subclk_sel_in(subclk), .timer_irq_out(irq)
  );
  cit_pulse_src u_src (
    .mclk_in(mclk_in), .start_in(start), .hi_in(hi_w), .lo_in(lo_w),
    .count_in(n_p), .pin_out(pin), .busy_out(busy)
  );

  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  // 16 system clocks per watch period, offset from the system edges
  initial begin
    watch_clk = 1'b0;
    #1;
    forever #40 watch_clk = ~watch_clk;
  end

  always begin
    @(rd_ev);
    tests_run++;
    if (hrdata !== exp_q[0]) begin
      $display("MISMATCH %s expected %h seen %h", nm_q[0], exp_q[0], hrdata);
      bad_count++;
    end
    if (hresp !== 1'b0) begin
      $display("MISMATCH hresp expected 0 seen %b", hresp);
      bad_count++;
    end
    void'(exp_q.pop_front());
    void'(nm_q.pop_front());
  end

  task automatic summarize();
    $display("counts: tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    hsize <= 3'h2;
    @(posedge mclk_in);
    while (hreadyout !== 1'b1) @(posedge mclk_in);
    htrans <= CIT_HTRANS_IDLE;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge mclk_in);
    while (hreadyout !== 1'b1) @(posedge mclk_in);
  endtask

  // idle cycle after a write: a read in its data phase would see the old value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
    @(posedge mclk_in);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input bit c, input string nm);
    if (c) begin
      exp_q.push_back(e);
      nm_q.push_back(nm);
    end
    xfer(1'b0, a, 32'h00000000);
    if (c) -> rd_ev;
  endtask

  task automatic clr_req();
    rd(CIT_OFS_REQ_FLAG, 32'h0, 1'b0, "req");
    wr(CIT_OFS_REQ_FLAG, 32'h0);
  endtask

  task automatic go(input logic [15:0] h, input logic [15:0] l, input logic [1:0] n);
    hi_w <= h;
    lo_w <= l;
    n_p <= n;
    start <= 1'b1;
    @(posedge mclk_in);
    start <= 1'b0;
    @(posedge mclk_in);
  endtask

  task automatic pwait();
    while (busy === 1'b1) @(posedge mclk_in);
    repeat (4) @(posedge mclk_in);
  endtask

  initial begin
    repeat (80000) @(posedge mclk_in);
    bad_count++;
    summarize();
  end

  initial begin
    nrst_in = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = CIT_HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pmode = CIT_PM_ACTIVE;
    subclk = CIT_SUB_W2;
    start = 1'b0;
    hi_w = 16'h0;
    lo_w = 16'h0;
    n_p = 2'h0;
    bad_count = 0;
    tests_run = 0;
    void'($urandom(19));
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    for (int a = 0; a < 32; a += 4) begin
      rd(8'(a), 32'h0, 1'b1, "reset value");
    end
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0, 1'b1, "unmapped");
    wr(CIT_OFS_FALL_CAP, 32'h000000FF);
    rd(CIT_OFS_FALL_CAP, 32'h0, 1'b1, "fall cap ro");
    $display("test 1 done");
    r = 8'($urandom()) & 8'h3F;
    wr(CIT_OFS_MODE, {24'h0, 8'hC0 | r});
    rd(CIT_OFS_MODE, {24'h0, r}, 1'b1, "mode rw");
    $display("test 2 done");
    wr(CIT_OFS_IRQ_EN, 32'h1);
    wr(CIT_OFS_MODE, 32'h22);
    for (int i = 0; i < 700 && irq !== 1'b1; i++) @(negedge mclk_in);
    chk("irq ovf", 1'b1, irq);
    @(posedge mclk_in);
    wr(CIT_OFS_MODE, 32'h22);
    rd(CIT_OFS_MODE, 32'h62, 1'b1, "overflow_low_flag kept");
    wr(CIT_OFS_MODE, 32'h22);
    rd(CIT_OFS_MODE, 32'h22, 1'b1, "overflow_low_flag cleared");
    wr(CIT_OFS_IRQ_EN, 32'h0);
    chk("irq masked", 1'b0, irq);
    rd(CIT_OFS_REQ_FLAG, 32'h1, 1'b1, "req ovf");
    wr(CIT_OFS_REQ_FLAG, 32'h0);
    rd(CIT_OFS_REQ_FLAG, 32'h0, 1'b1, "req cleared");
    $display("test 3 done");
    wr(CIT_OFS_PORT_FN, 32'h1);
    for (int c = 1; c < 3; c++) begin
      wr(CIT_OFS_MODE, {24'h0, 4'h0, 2'(c), CIT_CKS_DIV2});
      go(16'h0081, 16'h0041, 2'h2);
      pwait();
      rd(c == 1 ? CIT_OFS_RISE_CAP : CIT_OFS_FALL_CAP, c == 1 ? 32'h20 : 32'h40, 1'b1, "clr");
    end
    $display("test 4 done");
    for (int k = 0; k < 4; k++) begin
      wr(CIT_OFS_MODE, {24'h0, 4'h0, CIT_CCLR_BOTH, 2'(k)});
      clr_req();
      go(16'h0081, 16'h0041, 2'h2);
      pwait();
      rd(CIT_OFS_FALL_CAP, {24'h0, tabf[k]}, 1'b1, "fall cap");
      rd(CIT_OFS_RISE_CAP, {24'h0, tabr[k]}, 1'b1, "rise cap");
      rd(CIT_OFS_REQ_FLAG, 32'h1, 1'b1, "req edge");
    end
    $display("test 5 done");
    wr(CIT_OFS_MODE, {24'h0, 4'h0, CIT_CCLR_BOTH, CIT_CKS_DIV2});
    clr_req();
    pmode <= halt_m[$urandom_range(3, 0)];
    subclk <= cit_subclk_t'($urandom_range(2, 0));
    go(16'h0081, 16'h0041, 2'h2);
    pwait();
    rd(CIT_OFS_FALL_CAP, 32'h02, 1'b1, "halted fall");
    rd(CIT_OFS_RISE_CAP, 32'h01, 1'b1, "halted rise");
    rd(CIT_OFS_REQ_FLAG, 32'h0, 1'b1, "halted req");
    pmode <= CIT_PM_ACTIVE;
    $display("test 6 done");
    wr(CIT_OFS_PORT_FN, 32'h0);
    wr(CIT_OFS_PORT_FN, 32'h2);
    wr(CIT_OFS_PORT_FN, 32'h3);
    go(16'h0028, 16'h0028, 2'h1);
    pwait();
    clr_req();
    go(16'h0006, 16'h0028, 2'h1);
    pwait();
    rd(CIT_OFS_REQ_FLAG, 32'h0, 1'b1, "short pulse");
    go(16'h0029, 16'h0028, 2'h1);
    repeat (4) @(posedge mclk_in);
    rd(CIT_OFS_REQ_FLAG, 32'h0, 1'b1, "filter delay");
    pwait();
    rd(CIT_OFS_REQ_FLAG, 32'h1, 1'b1, "long pulse");
    $display("test 7 done");
    wr(CIT_OFS_PORT_FN, 32'h0);
    wr(CIT_OFS_IRQ_EN, 32'h1);
    wr(CIT_OFS_MODE, 32'h2A);
    rd(CIT_OFS_MODE, 32'h0, 1'b0, "mode");
    wr(CIT_OFS_MODE, 32'h2A);
    clr_req();
    go(16'h02BC, 16'h0002, 2'h1);
    repeat (10) @(posedge mclk_in);
    wr(CIT_OFS_PORT_FN, 32'h1);
    repeat (10) @(posedge mclk_in);
    rd(CIT_OFS_REQ_FLAG, 32'h1, 1'b1, "switch edge");
    rd(CIT_OFS_MODE, 32'h0, 1'b0, "mode");
    wr(CIT_OFS_MODE, 32'h2A);
    wr(CIT_OFS_REQ_FLAG, 32'h0);
    repeat (560) @(negedge mclk_in);
    chk("irq overflow_high_flag", 1'b1, irq);
    @(posedge mclk_in);
    pwait();
    rd(CIT_OFS_MODE, 32'hAA, 1'b1, "overflow_high_flag");
    $display("test 8 done");
    wr(CIT_OFS_MODE, 32'h16);
    clr_req();
    go(16'h0081, 16'h0041, 2'h1);
    repeat (20) @(posedge mclk_in);
    rd(CIT_OFS_REQ_FLAG, 32'h0, 1'b1, "rise ignored");
    pwait();
    rd(CIT_OFS_REQ_FLAG, 32'h1, 1'b1, "req fall");
    clr_req();
    wr(CIT_OFS_CLK_HALT, 32'h1);
    go(16'h0081, 16'h0041, 2'h1);
    pwait();
    rd(CIT_OFS_REQ_FLAG, 32'h0, 1'b1, "stopped");
    wr(CIT_OFS_CLK_HALT, 32'h0);
    wr(CIT_OFS_MODE, 32'h0F);
    pmode <= CIT_PM_SUBSLEEP;
    subclk <= CIT_SUB_W2;
    go(16'h0081, 16'h0041, 2'h2);
    pwait();
    rd(CIT_OFS_FALL_CAP, 32'h02, 1'b1, "sub fall");
    rd(CIT_OFS_RISE_CAP, 32'h01, 1'b1, "sub rise");
    pmode <= CIT_PM_ACTIVE;
    $display("test 9 done");
    summarize();
  end
endmodule
